// ---- include/dhiw_pkg.sv ----
/*
 * Shared constants and types for the dual host interlock and watchdog block.
 * Assumes one 125 MHz clock per board and an identical board across the cable.
 */
package dhiw_pkg;

    // Register offsets, byte addresses on the Wishbone slave
    localparam logic [7:0]  REG_CMD      = 8'h00;
    localparam logic [7:0]  REG_ACC      = 8'h04;
    localparam logic [7:0]  REG_STATUS   = 8'h08;
    localparam logic [7:0]  REG_MASK     = 8'h0c;

    // I/O device select codes (36 and 37 octal)
    localparam logic [5:0]  DEV_LINK     = 6'h1e;
    localparam logic [5:0]  DEV_WDOG     = 6'h1f;

    // Priority mask bit shared by both devices
    localparam int          MASK_BIT     = 6;
    localparam logic [15:0] MASK_RST     = 16'h0000;

    // Status register bit positions
    localparam int          SB_BUSY      = 0;
    localparam int          SB_DONE      = 1;
    localparam int          SB_WD_DONE   = 2;
    localparam int          SB_PEER_BUSY = 3;
    localparam int          SB_INTR      = 4;
    localparam int          SB_ARB       = 5;

    // Timing
    localparam int          CLK_HZ       = 125_000_000;
    localparam int          WD_PERIOD_S  = 1;
    localparam int          WD_CYC       = WD_PERIOD_S * CLK_HZ;
    localparam logic [3:0]  ARB_CYC      = 4'h6;

    typedef enum logic [2:0] {
        OP_NOOP_IO      = 3'b000,
        OP_READ_DATA_A  = 3'b001,
        OP_WRITE_DATA_A = 3'b010,
        OP_READ_DATA_B  = 3'b011
    } dhiw_op_t;

    typedef enum logic [1:0] {
        FN_NONE  = 2'b00,
        FN_START = 2'b01,
        FN_CLEAR = 2'b10,
        FN_PULSE = 2'b11
    } dhiw_fn_t;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_LINK = 2'b01,
        SRC_WDOG = 2'b10
    } dhiw_src_t;

    typedef enum logic {
        ARB_IDLE = 1'b0,
        ARB_WAIT = 1'b1
    } dhiw_state_t;

    // Command word written to REG_CMD
    typedef struct packed {
        logic [4:0] rsvd;
        dhiw_fn_t   func;
        dhiw_op_t   op;
        logic [5:0] code;
        logic [15:0] ac;
    } dhiw_cmd_t;

    // One direction of the board-to-board cable
    typedef struct packed {
        logic        busy;
        logic        claim;
        logic        bclr_tg;
        logic        dset_tg;
        logic        wdrst_tg;
        logic        wdset_tg;
        logic        xfer_tg;
        logic [15:0] xfer_data;
    } dhiw_cable_t;

endpackage : dhiw_pkg

// ---- sim/dhiw_peer_model.sv ----
/*
 * Behavioural twin board for the link bench: counts cable events from the
 * device, stores its word and keeps the device's watchdog alive on request.
 * Assumes it shares mclk with the device and is driven by bench tasks.
 */
`timescale 1ns/1ps
module dhiw_peer_model
    import dhiw_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   reset_n,
    input  dhiw_cable_t from_dev,
    output dhiw_cable_t to_dev
);
    logic        keepalive;
    logic [6:0]  ka_cnt;
    logic [15:0] buf_q;
    logic [7:0]  n_dset;
    logic [7:0]  n_bclr;
    logic [7:0]  n_wdrst;
    logic [7:0]  n_wdset;
    dhiw_cable_t seen;

    initial begin
        keepalive = 1'h1;
        to_dev = '0;
    end

    always @(posedge mclk) begin
        seen <= from_dev;
        if (!reset_n) begin
            ka_cnt <= 7'h0;
            buf_q <= 16'h0;
            n_dset <= 8'h0;
            n_bclr <= 8'h0;
            n_wdrst <= 8'h0;
            n_wdset <= 8'h0;
        end else begin
            ka_cnt <= ka_cnt + 7'h1;
            // Restart period of 128 cycles stays inside the short timer
            if (keepalive && ka_cnt == 7'h0) to_dev.wdrst_tg <= ~to_dev.wdrst_tg;
            if (seen.xfer_tg != from_dev.xfer_tg) buf_q <= from_dev.xfer_data;
            if (seen.dset_tg != from_dev.dset_tg) n_dset <= n_dset + 8'h1;
            if (seen.bclr_tg != from_dev.bclr_tg) begin
                n_bclr <= n_bclr + 8'h1;
                to_dev.busy <= 1'h0;
            end
            if (seen.wdrst_tg != from_dev.wdrst_tg) n_wdrst <= n_wdrst + 8'h1;
            if (seen.wdset_tg != from_dev.wdset_tg) n_wdset <= n_wdset + 8'h1;
        end
    end

    task automatic ev(input int k);
        case (k)
            0: to_dev.bclr_tg <= ~to_dev.bclr_tg;
            1: to_dev.dset_tg <= ~to_dev.dset_tg;
            default: to_dev.wdset_tg <= ~to_dev.wdset_tg;
        endcase
    endtask : ev

    task automatic send(input logic [15:0] d);
        to_dev.xfer_data <= d;
        to_dev.xfer_tg <= ~to_dev.xfer_tg;
    endtask : send

    // Claim without busy models a twin that starts in the same moment
    task automatic set_busy(input logic b, input logic c);
        to_dev.busy <= b;
        to_dev.claim <= c;
    endtask : set_busy
endmodule : dhiw_peer_model

// ---- sim/testbench.sv ----
/*
 * Self-checking bench for the link and watchdog block against a twin model.
 * Assumes one clock, a 200 cycle watchdog period and sequential bus calls.
 */
`timescale 1ns/1ps
module testbench
    import dhiw_pkg::*;
;
    localparam int WDC = 200;
    logic        mclk;
    logic        reset_n;
    logic        primary;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    dhiw_cable_t link_i;
    dhiw_cable_t link_o;
    logic        intr_req;
    dhiw_src_t   intr_src;
    int          mismatches;
    int          n_checks;
    logic [31:0] q;
    logic [7:0]  c0;
    logic        ce;
    logic [3:0]  wb_sel_i;
    logic [3:0]  sel_q;
    int          lat;

    dhiw_link #(.WD_CYCLES(WDC)) dhiw_link_i (
        .mclk(mclk), .reset_n(reset_n), .ce(ce), .primary(primary),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_i(link_i),
        .link_o(link_o), .intr_req(intr_req), .intr_src(intr_src));

    dhiw_peer_model dhiw_peer_model_i (
        .mclk(mclk), .reset_n(reset_n), .from_dev(link_o), .to_dev(link_i));

    always #4 mclk = ~mclk;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_sel_i <= sel_q;
        wb_adr_i <= a;
        wb_dat_i <= d;
        lat = 0;
        // Only the bench watchdog ends a wait for ack
        do begin
            @(posedge mclk);
            lat++;
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    task automatic cmd(input dhiw_op_t o, input dhiw_fn_t f, input logic [5:0] c,
                       input logic [15:0] ac);
        dhiw_cmd_t w;
        w = '{rsvd: 5'h0, func: f, op: o, code: c, ac: ac};
        wb(1'h1, REG_CMD, w);
    endtask : cmd

    task automatic st(input int b, input logic e);
        wb(1'h0, REG_STATUS, 32'h0);
        chk($sformatf("status_bit%0d", b), {31'h0, e}, {31'h0, q[b]});
    endtask : st

    task automatic settle();
        repeat (6) @(posedge mclk);
    endtask : settle

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    initial begin
        mclk = 1'h0;
        reset_n = 1'h0;
        primary = 1'h0;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        ce = 1'h1;
        wb_sel_i = 4'hf;
        sel_q = 4'hf;
        mismatches = 0;
        n_checks = 0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        wb(1'h0, REG_STATUS, 32'h0);
        chk("status_reset", 32'h0, q);
        wb(1'h0, REG_MASK, 32'h0);
        chk("mask_reset", 32'h0, q);
        chk("ack_lat", 32'h2, 32'(lat));
        wb(1'h1, 8'h10, 32'hffff_ffff);
        wb(1'h0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");

        c0 = dhiw_peer_model_i.n_dset;
        cmd(OP_WRITE_DATA_A, FN_PULSE, DEV_LINK, 16'ha5c3);
        settle();
        chk("peer_buf", 32'ha5c3, 32'(dhiw_peer_model_i.buf_q));
        chk("peer_done", 32'(c0 + 8'h1), 32'(dhiw_peer_model_i.n_dset));
        @(posedge mclk);
        dhiw_peer_model_i.send(16'h3c5a);
        dhiw_peer_model_i.ev(1);
        settle();
        st(SB_DONE, 1'h1);
        chk("intr_src", 32'(SRC_LINK), 32'(intr_src));
        cmd(OP_READ_DATA_A, FN_PULSE, DEV_LINK, 16'h0);
        wb(1'h0, REG_ACC, 32'h0);
        chk("acc", 32'h3c5a, q);
        st(SB_DONE, 1'h0);
        chk("intr_req", 32'h0, 32'(intr_req));
        chk("peer_done", 32'(c0 + 8'h2), 32'(dhiw_peer_model_i.n_dset));
        cmd(OP_READ_DATA_A, FN_NONE, DEV_LINK, 16'h0);
        wb(1'h0, REG_ACC, 32'h0);
        chk("acc_kept", 32'h3c5a, q);
        $display("test data done");

        cmd(OP_NOOP_IO, FN_START, 6'h1d, 16'h0);
        st(SB_BUSY, 1'h0);
        sel_q = 4'h3;
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        sel_q = 4'hf;
        st(SB_BUSY, 1'h0);
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        chk("start_lat", 32'(ARB_CYC) + 32'h2, 32'(lat));
        st(SB_BUSY, 1'h1);
        chk("busy_out", 32'h1, 32'(link_o.busy));
        c0 = dhiw_peer_model_i.n_bclr;
        cmd(OP_NOOP_IO, FN_CLEAR, DEV_LINK, 16'h0);
        settle();
        chk("peer_bclr", 32'(c0 + 8'h1), 32'(dhiw_peer_model_i.n_bclr));
        dhiw_peer_model_i.ev(0);
        settle();
        st(SB_BUSY, 1'h0);
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        dhiw_peer_model_i.ev(1);
        settle();
        st(SB_DONE, 1'h1);
        cmd(OP_READ_DATA_B, FN_NONE, DEV_LINK, 16'h0);
        st(SB_BUSY, 1'h0);
        st(SB_DONE, 1'h0);
        dhiw_peer_model_i.set_busy(1'h1, 1'h0);
        settle();
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        st(SB_BUSY, 1'h0);
        dhiw_peer_model_i.set_busy(1'h0, 1'h0);
        settle();
        @(posedge mclk);
        dhiw_peer_model_i.set_busy(1'h0, 1'h1);
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        dhiw_peer_model_i.set_busy(1'h1, 1'h0);
        st(SB_BUSY, 1'h0);
        dhiw_peer_model_i.set_busy(1'h0, 1'h0);
        settle();
        primary <= 1'h1;
        dhiw_peer_model_i.set_busy(1'h0, 1'h1);
        settle();
        cmd(OP_NOOP_IO, FN_START, DEV_LINK, 16'h0);
        st(SB_BUSY, 1'h1);
        cmd(OP_READ_DATA_B, FN_NONE, DEV_LINK, 16'h0);
        dhiw_peer_model_i.set_busy(1'h0, 1'h0);
        $display("test interlock done");

        c0 = dhiw_peer_model_i.n_wdrst;
        cmd(OP_NOOP_IO, FN_START, DEV_WDOG, 16'h0);
        settle();
        chk("peer_restart", 32'(c0 + 8'h1), 32'(dhiw_peer_model_i.n_wdrst));
        c0 = dhiw_peer_model_i.n_wdset;
        cmd(OP_NOOP_IO, FN_PULSE, DEV_WDOG, 16'h0);
        settle();
        chk("peer_wdset", 32'(c0 + 8'h1), 32'(dhiw_peer_model_i.n_wdset));
        dhiw_peer_model_i.ev(2);
        settle();
        st(SB_WD_DONE, 1'h1);
        chk("src_wdog", 32'(SRC_WDOG), 32'(intr_src));
        dhiw_peer_model_i.ev(1);
        settle();
        chk("src_both", 32'(SRC_LINK), 32'(intr_src));
        wb(1'h1, REG_MASK, 32'h0040);
        chk("masked", 32'h0, 32'(intr_req));
        wb(1'h1, REG_MASK, 32'h0);
        cmd(OP_NOOP_IO, FN_CLEAR, DEV_WDOG, 16'h0);
        st(SB_WD_DONE, 1'h0);
        cmd(OP_READ_DATA_B, FN_NONE, DEV_LINK, 16'h0);
        chk("req_drop", 32'h0, 32'(intr_req));
        dhiw_peer_model_i.keepalive <= 1'h0;
        cmd(OP_WRITE_DATA_A, FN_NONE, DEV_WDOG, 16'h0);
        repeat (120) @(posedge mclk);
        cmd(OP_WRITE_DATA_A, FN_NONE, DEV_WDOG, 16'h0);
        repeat (120) @(posedge mclk);
        st(SB_WD_DONE, 1'h0);
        // Frozen timer must not reach expiry while ce is low
        ce <= 1'h0;
        repeat (100) @(posedge mclk);
        ce <= 1'h1;
        chk("ce_freeze", 32'h0, 32'(intr_req));
        repeat (100) @(posedge mclk);
        st(SB_WD_DONE, 1'h1);
        repeat (300) @(posedge mclk);
        st(SB_WD_DONE, 1'h1);
        chk("src_hold", 32'(SRC_WDOG), 32'(intr_src));
        $display("test watchdog done");
        summarize();
    end
endmodule : testbench

// ---- verilog/dhiw_link.sv ----
/*
 * Half-duplex interlocked link and peer watchdog, one board of a pair.
 * Software drives it over classic Wishbone; the twin board sits on link_i/link_o.
 * Assumes the twin runs the same logic on its own unrelated clock.
 */
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - One buffer shared by both boards; every write reaches both copies except a peer write landing with a local write
// - Start sets local busy only while peer busy reads zero
// - Simultaneous starts: arbitration leaves exactly one busy flag set
// - Clear zeroes local done and the peer's busy flag
// - Pulse zeroes local done and sets the peer's done flag
// - Read copies buffer into accumulator, buffer kept, then flag action
// - Write loads 16 accumulator bits into buffer, then flag action
// - Second register read clears local busy and done; accumulator set to zero
// - Link answers device code 36 octal
// - Watchdog answers device code 37 octal
// - Mask bit 6 blocks both interrupt requests
// - One second without restart sets watchdog done and requests interrupt
// - Watchdog start restarts the peer's timer
// - Watchdog clear zeroes the local watchdog done flag
// - Watchdog pulse sets the peer's watchdog done flag at once
// - Watchdog data output restarts the local timer
// - Watchdog done holds, with its request, until software clears it
// - Link request outranks watchdog request when both pend
module dhiw_link
    import dhiw_pkg::*;
#(
    parameter int WD_CYCLES = WD_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        primary,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  dhiw_cable_t      link_i,
    output dhiw_cable_t      link_o,
    output logic             intr_req,
    output dhiw_src_t        intr_src
);

    localparam int             WDW     = $clog2(WD_CYCLES + 1);
    localparam logic [WDW-1:0] WD_LAST = WDW'(WD_CYCLES - 1);
    localparam logic [WDW-1:0] WD_STOP = WDW'(WD_CYCLES);
    localparam int             NSYNC   = 7;

    dhiw_state_t    st_r;
    logic [3:0]     arb_cnt_r;
    logic           ack_r;
    logic [31:0]    dat_r;
    logic           busy_r;
    logic           done_r;
    logic           wd_done_r;
    logic [WDW-1:0] wd_cnt_r;
    logic [15:0]    buf_r;
    logic [15:0]    acc_r;
    logic [15:0]    mask_r;
    logic [15:0]    xfer_r;
    logic [4:0]     tg_out_r;
    logic [4:0]     tg_prev_r;

    logic           busy_nxt;
    logic           done_nxt;
    logic           wd_done_nxt;
    logic [WDW-1:0] wd_cnt_nxt;
    logic [15:0]    buf_nxt;
    logic [15:0]    acc_nxt;
    logic [31:0]    rd_nxt;
    logic [31:0]    status;

    // Cable side into the local clock
    logic [NSYNC-1:0] peer_raw;
    logic [NSYNC-1:0] peer_s;

    assign peer_raw = {link_i.busy, link_i.claim, link_i.bclr_tg, link_i.dset_tg,
                       link_i.wdrst_tg, link_i.wdset_tg, link_i.xfer_tg};

    dhiw_sync #(
        .W       (NSYNC)
    ) u_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .ce      (ce),
        .d       (peer_raw),
        .q       (peer_s)
    );

    wire       peer_busy_s  = peer_s[6];
    wire       peer_claim_s = peer_s[5];
    // Both boards must leave reset together or a stray toggle event appears
    wire [4:0] tg_ev        = peer_s[4:0] ^ tg_prev_r;
    wire       ev_bclr      = tg_ev[4];
    wire       ev_dset      = tg_ev[3];
    wire       ev_wdrst     = tg_ev[2];
    wire       ev_wdset     = tg_ev[1];
    wire       ev_xfer      = tg_ev[0];

    // Bus decode
    dhiw_cmd_t cmd;
    assign cmd = dhiw_cmd_t'(wb_dat_i);

    wire req_new    = wb_cyc_i & wb_stb_i & ~ack_r & (st_r == ARB_IDLE);
    wire hit_cmd    = (wb_adr_i == REG_CMD);
    wire hit_acc    = (wb_adr_i == REG_ACC);
    wire hit_status = (wb_adr_i == REG_STATUS);
    wire hit_mask   = (wb_adr_i == REG_MASK);
    wire go         = ce & req_new & wb_we_i & hit_cmd & (wb_sel_i == 4'hf);
    wire mask_wr    = ce & req_new & wb_we_i & hit_mask;
    wire rd_go      = ce & req_new & ~wb_we_i;

    wire lk_go      = go & (cmd.code == DEV_LINK);
    wire wd_go      = go & (cmd.code == DEV_WDOG);

    // Link instructions; second register read takes no function
    wire lk_dib     = lk_go & (cmd.op == OP_READ_DATA_B);
    wire lk_fn      = lk_go & ~lk_dib;
    wire lk_rd      = lk_go & (cmd.op == OP_READ_DATA_A);
    wire lk_wr      = lk_go & (cmd.op == OP_WRITE_DATA_A);
    wire lk_start   = lk_fn & (cmd.func == FN_START);
    wire lk_clear   = lk_fn & (cmd.func == FN_CLEAR);
    wire lk_pulse   = lk_fn & (cmd.func == FN_PULSE);

    // Watchdog instructions
    wire wd_fn      = wd_go & (cmd.op != OP_READ_DATA_B);
    wire wd_start   = wd_fn & (cmd.func == FN_START);
    wire wd_clear   = wd_fn & (cmd.func == FN_CLEAR);
    wire wd_pulse   = wd_fn & (cmd.func == FN_PULSE);
    wire wd_own     = wd_go & (cmd.op == OP_WRITE_DATA_A);

    // Interlock arbitration: claim, wait for the peer to see it, then decide
    wire arb_begin  = lk_start & ~busy_r & ~peer_busy_s;
    wire arb_end    = ce & (st_r == ARB_WAIT) & (arb_cnt_r == ARB_CYC - 4'h1);
    // Window outlasts the cable sync, so a later claimer sees our busy
    wire arb_win    = arb_end & ~peer_busy_s & (primary | ~peer_claim_s);
    wire ack_nxt    = (ce & req_new & ~arb_begin) | arb_end;

    // Watchdog timer
    wire wd_restart = ev_wdrst | wd_own;
    wire wd_expire  = ~wd_restart & (wd_cnt_r == WD_LAST);

    always_comb begin
        wd_cnt_nxt = wd_cnt_r;
        if (wd_restart) begin
            wd_cnt_nxt = '0;
        end else if (wd_cnt_r != WD_STOP) begin
            wd_cnt_nxt = wd_cnt_r + WDW'(1);
        end
    end

    // Flag updates; every hardware set wins over a same-cycle clear
    always_comb begin
        busy_nxt = busy_r;
        if (lk_dib | ev_bclr) begin
            busy_nxt = 1'b0;
        end
        if (arb_win) begin
            busy_nxt = 1'b1;
        end
    end

    always_comb begin
        done_nxt = done_r;
        if (lk_dib | lk_clear | lk_pulse) begin
            done_nxt = 1'b0;
        end
        if (ev_dset) begin
            done_nxt = 1'b1;
        end
    end

    always_comb begin
        wd_done_nxt = wd_done_r;
        if (wd_clear) begin
            wd_done_nxt = 1'b0;
        end
        if (wd_expire | ev_wdset) begin
            wd_done_nxt = 1'b1;
        end
    end

    // Local copy of the shared buffer; a local write overrides a crossing one
    always_comb begin
        buf_nxt = buf_r;
        if (ev_xfer) begin
            buf_nxt = link_i.xfer_data;
        end
        if (lk_wr) begin
            buf_nxt = cmd.ac;
        end
    end

    always_comb begin
        acc_nxt = acc_r;
        if (lk_rd) begin
            acc_nxt = buf_r;
        end else if (lk_dib) begin
            acc_nxt = 16'h0000;
        end
    end

    // Interrupt request, link ahead of watchdog
    wire irq_masked = mask_r[MASK_BIT];
    assign intr_req = ~irq_masked & (done_r | wd_done_r);
    assign intr_src = irq_masked ? SRC_NONE :
                      done_r     ? SRC_LINK :
                      wd_done_r  ? SRC_WDOG : SRC_NONE;

    always_comb begin
        status               = 32'h0000_0000;
        status[SB_BUSY]      = busy_r;
        status[SB_DONE]      = done_r;
        status[SB_WD_DONE]   = wd_done_r;
        status[SB_PEER_BUSY] = peer_busy_s;
        status[SB_INTR]      = intr_req;
        status[SB_ARB]       = (st_r == ARB_WAIT);
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit_acc) begin
            rd_nxt = {16'h0000, acc_r};
        end else if (hit_status) begin
            rd_nxt = status;
        end else if (hit_mask) begin
            rd_nxt = {16'h0000, mask_r};
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r      <= ARB_IDLE;
            arb_cnt_r <= 4'h0;
        end else if (ce) begin
            case (st_r)
                ARB_IDLE: begin
                    if (arb_begin) begin
                        st_r <= ARB_WAIT;
                    end
                    arb_cnt_r <= 4'h0;
                end
                ARB_WAIT: begin
                    if (arb_end) begin
                        st_r <= ARB_IDLE;
                    end
                    arb_cnt_r <= arb_cnt_r + 4'h1;
                end
                default: begin
                    st_r <= ARB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else if (ce) begin
            ack_r <= ack_nxt;
            if (rd_go) begin
                dat_r <= rd_nxt;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            busy_r    <= 1'b0;
            done_r    <= 1'b0;
            wd_done_r <= 1'b0;
            wd_cnt_r  <= '0;
            buf_r     <= 16'h0000;
            acc_r     <= 16'h0000;
            tg_prev_r <= 5'h00;
        end else if (ce) begin
            busy_r    <= busy_nxt;
            done_r    <= done_nxt;
            wd_done_r <= wd_done_nxt;
            wd_cnt_r  <= wd_cnt_nxt;
            buf_r     <= buf_nxt;
            acc_r     <= acc_nxt;
            tg_prev_r <= peer_s[4:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mask_r <= MASK_RST;
        end else if (mask_wr) begin
            if (wb_sel_i[0]) begin
                mask_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                mask_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // Events to the peer; data is set in the same edge as its toggle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            tg_out_r <= 5'h00;
            xfer_r   <= 16'h0000;
        end else if (ce) begin
            if (lk_clear) begin
                tg_out_r[4] <= ~tg_out_r[4];
            end
            if (lk_pulse) begin
                tg_out_r[3] <= ~tg_out_r[3];
            end
            if (wd_start) begin
                tg_out_r[2] <= ~tg_out_r[2];
            end
            if (wd_pulse) begin
                tg_out_r[1] <= ~tg_out_r[1];
            end
            if (lk_wr) begin
                tg_out_r[0] <= ~tg_out_r[0];
                xfer_r      <= cmd.ac;
            end
        end
    end

    assign link_o.busy      = busy_r;
    assign link_o.claim     = (st_r == ARB_WAIT);
    assign link_o.bclr_tg   = tg_out_r[4];
    assign link_o.dset_tg   = tg_out_r[3];
    assign link_o.wdrst_tg  = tg_out_r[2];
    assign link_o.wdset_tg  = tg_out_r[1];
    assign link_o.xfer_tg   = tg_out_r[0];
    assign link_o.xfer_data = xfer_r;
    assign wb_ack_o         = ack_r;
    assign wb_dat_o         = dat_r;

    default clocking dflt_cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    AST_NO_STEAL: assert property (
        $rose(busy_r) |-> $past(st_r == ARB_WAIT && !peer_busy_s))
        else $error("Busy set while peer busy");

    AST_ARB_YIELD: assert property (
        $rose(busy_r) && !primary |-> $past(!peer_claim_s))
        else $error("Secondary took busy against a peer claim");

    AST_CLEAR_PEER: assert property (
        lk_clear |=> link_o.bclr_tg != $past(link_o.bclr_tg) && !done_r || $past(ev_dset))
        else $error("Clear did not reach the peer busy flag");

    AST_PULSE_PEER: assert property (
        lk_pulse && !ev_dset |=> link_o.dset_tg != $past(link_o.dset_tg) && !done_r)
        else $error("Pulse did not set peer done");

    AST_READ: assert property (
        lk_rd && !ev_xfer |=> acc_r == $past(buf_r) && $stable(buf_r))
        else $error("Read did not copy the buffer");

    AST_WRITE: assert property (
        lk_wr |=> buf_r == $past(cmd.ac) && link_o.xfer_data == buf_r)
        else $error("Write did not load the buffer");

    AST_DIB: assert property (
        lk_dib && !ev_dset |=> !busy_r && !done_r)
        else $error("Second register read left a flag set");

    AST_MASK: assert property (
        mask_r[MASK_BIT] |-> !intr_req && intr_src == SRC_NONE)
        else $error("Request passed the mask");

    AST_WD_EXPIRE: assert property (
        ce && wd_cnt_r == WD_LAST && !wd_restart |=> wd_done_r)
        else $error("Watchdog expiry missed");

    AST_WD_PEER: assert property (
        wd_start |=> link_o.wdrst_tg != $past(link_o.wdrst_tg))
        else $error("Watchdog start not sent to peer");

    AST_WD_CLEAR: assert property (
        wd_clear && !wd_expire && !ev_wdset |=> !wd_done_r)
        else $error("Watchdog clear ignored");

    AST_WD_SET: assert property (
        wd_pulse |=> link_o.wdset_tg != $past(link_o.wdset_tg))
        else $error("Watchdog pulse not sent to peer");

    AST_WD_OWN: assert property (
        wd_own |=> wd_cnt_r == '0)
        else $error("Own timer not restarted");

    AST_WD_HOLD: assert property (
        wd_done_r && !wd_clear |=> wd_done_r)
        else $error("Watchdog done dropped on its own");

    AST_PRIO: assert property (
        done_r && wd_done_r && !mask_r[MASK_BIT] |-> intr_src == SRC_LINK)
        else $error("Watchdog outranked the link");

    AST_IRQ_DROP: assert property (
        $fell(done_r) && !wd_done_r |-> !intr_req)
        else $error("Link request outlived its done flag");

endmodule : dhiw_link

// ---- verilog/dhiw_sync.sv ----
/*
 * Two flip-flop level synchroniser, W bits wide.
 * Assumes each bit is a level or a toggle that stays put for several clocks.
 */
`timescale 1ns/1ps
module dhiw_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            meta_r <= '0;
            q      <= '0;
        end else if (ce) begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : dhiw_sync
